/* File: logic/sram_defines.svh */
`ifndef SRAM_DEFINES_SVH
`define SRAM_DEFINES_SVH
`define ADDR_W 18
`define DATA_W 32
`define LANES 4
`define LANE_W 8
`define DEPTH 262144
`define BURST_W 2
`define ALL_LANES 4'hF
`define NO_LANES 4'h0
`endif

/* File: logic/sram_pkg.sv */
`include "sram_defines.svh"
package sram_pkg;
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic proc_strobe_b;
        logic ctrl_strobe_b;
        logic advance_b;
        logic cs_primary_b;
        logic cs_high;
        logic cs_third_b;
        logic [`LANES-1:0] lanes_b;
        logic lane_gate_b;
        logic write_all_b;
    } bus_in_t;
    typedef enum logic [1:0] {
        ST_DESEL = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b11
    } cycle_t;
endpackage

/* File: logic/burst_counter.sv */
`include "sram_defines.svh"
module burst_counter #(
    parameter int W = `BURST_W
) (
    input wire logic sys_clk,
    input wire logic rst_sync_b,
    input wire logic load,
    input wire logic [W-1:0] start,
    input wire logic step,
    input wire logic linear_mode,
    output logic [W-1:0] low_bits
);
    logic [W-1:0] start_r;
    logic [W-1:0] count_r;
    // counter wraps in W bits, upper address untouched
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            start_r <= '0;
            count_r <= '0;
        end else if (load) begin
            start_r <= start;
            count_r <= '0;
        end else if (step) begin
            count_r <= count_r + W'(1);
        end
    end
    // interleaved order xors the start with the step count
    always_comb begin
        if (linear_mode)
            low_bits = start_r + count_r;
        else
            low_bits = start_r ^ count_r;
    end
endmodule

/* File: logic/pipelined_burst_sync_sram.sv */
`include "sram_defines.svh"
module pipelined_burst_sync_sram #(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W,
    parameter int DEPTH = `DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic processor_address_strobe_b,
    input wire logic controller_address_strobe_b,
    input wire logic burst_advance_b,
    input wire logic chip_select_primary_b,
    input wire logic chip_select_active_high,
    input wire logic chip_select_third_b,
    input wire logic [`LANES-1:0] byte_lane_selects_b,
    input wire logic byte_write_gate_b,
    input wire logic write_all_lanes_b,
    input wire logic output_enable_b,
    input wire logic sleep_request,
    input wire logic linear_burst,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe
);
    logic [1:0] rst_sync_r;
    logic rst_sync_b;
    sram_pkg::bus_in_t in_r;
    logic [DATA_W-1:0] din_r;
    logic [ADDR_W-1:0] addr_r;
    sram_pkg::cycle_t cyc_r;
    logic selected;
    logic proc_go;
    logic ctrl_go;
    logic load;
    logic [`BURST_W-1:0] low_bits;
    logic [ADDR_W-1:0] word_addr;
    logic [`LANES-1:0] wr_lanes;
    logic first_read_r;
    logic from_desel_r;
    logic rd_valid_r;
    logic [DATA_W-1:0] q_r;
    logic [DATA_W-1:0] mem [DEPTH];

    // reset release through two flops; the memory itself has no reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_sync_b = rst_sync_r[1];

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            in_r <= '1;
            din_r <= '0;
        end else begin
            in_r.addr <= addr;
            in_r.proc_strobe_b <= processor_address_strobe_b;
            in_r.ctrl_strobe_b <= controller_address_strobe_b;
            in_r.advance_b <= burst_advance_b;
            in_r.cs_primary_b <= chip_select_primary_b;
            in_r.cs_high <= chip_select_active_high;
            in_r.cs_third_b <= chip_select_third_b;
            in_r.lanes_b <= byte_lane_selects_b;
            in_r.lane_gate_b <= byte_write_gate_b;
            in_r.write_all_b <= write_all_lanes_b;
            din_r <= dq_in;
        end
    end

    assign selected = !in_r.cs_primary_b && in_r.cs_high
        && !in_r.cs_third_b;
    // processor strobe gated by primary select
    assign proc_go = !in_r.proc_strobe_b && !in_r.cs_primary_b;
    assign ctrl_go = !in_r.ctrl_strobe_b && !proc_go;
    assign load = proc_go || ctrl_go;

    always_comb begin
        if (!in_r.write_all_b)
            wr_lanes = `ALL_LANES;
        else if (!in_r.lane_gate_b)
            wr_lanes = ~in_r.lanes_b;
        else
            wr_lanes = `NO_LANES;
    end

    // address register; a selected processor-strobe load always opens a read
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            addr_r <= '0;
            cyc_r <= sram_pkg::ST_DESEL;
        end else if (load) begin
            addr_r <= in_r.addr;
            if (!selected)
                cyc_r <= sram_pkg::ST_DESEL;
            else if (ctrl_go && wr_lanes != `NO_LANES)
                cyc_r <= sram_pkg::ST_WRITE;
            else
                cyc_r <= sram_pkg::ST_READ;
        end else if (cyc_r != sram_pkg::ST_DESEL) begin
            if (wr_lanes != `NO_LANES)
                cyc_r <= sram_pkg::ST_WRITE;
            else
                cyc_r <= sram_pkg::ST_READ;
        end
    end

    burst_counter #(.W(`BURST_W)) u_burst (
        .sys_clk(sys_clk),
        .rst_sync_b(rst_sync_b),
        .load(load),
        .start(in_r.addr[`BURST_W-1:0]),
        .step(!load && !in_r.advance_b),
        .linear_mode(linear_burst),
        .low_bits(low_bits)
    );
    assign word_addr = {addr_r[ADDR_W-1:`BURST_W], low_bits};

    // self-timed write two cycles after capture
    // din_r lags one edge, so data with write controls is registered
    logic [DATA_W-1:0] wdata_r;
    logic [`LANES-1:0] wlanes_r;
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wdata_r <= '0;
            wlanes_r <= `NO_LANES;
        end else begin
            wdata_r <= din_r;
            // strobe writes need selects and the controller strobe;
            // later beats write inside an open selected cycle
            if (load)
                wlanes_r <= (selected && ctrl_go) ? wr_lanes : `NO_LANES;
            else
                wlanes_r <= (cyc_r != sram_pkg::ST_DESEL) ? wr_lanes
                    : `NO_LANES;
        end
    end
    // word_addr has settled on the beat's address one edge after capture
    always_ff @(posedge sys_clk) begin
        // array keeps contents; writes continue only when awake
        if (!sleep_request) begin
            for (int i = 0; i < `LANES; i++) begin
                if (wlanes_r[i])
                    mem[word_addr][i*`LANE_W +: `LANE_W] <=
                        wdata_r[i*`LANE_W +: `LANE_W];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            q_r <= '0;
            rd_valid_r <= 1'b0;
            first_read_r <= 1'b0;
            from_desel_r <= 1'b0;
        end else begin
            q_r <= mem[word_addr];
            rd_valid_r <= (cyc_r == sram_pkg::ST_READ) && !load;
            // remember a cycle opened from deselect until data flows
            if (load && selected)
                from_desel_r <= (cyc_r == sram_pkg::ST_DESEL);
            else if (rd_valid_r)
                from_desel_r <= 1'b0;
            // mask lands on the edge that presents word 0
            first_read_r <= from_desel_r && !load && !rd_valid_r
                && cyc_r == sram_pkg::ST_READ;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b)
            dq_out <= '0;
        else
            dq_out <= q_r;
    end
    // async disable, sync enable, masked on first read
    always_ff @(posedge sys_clk or posedge output_enable_b
        or posedge sleep_request or negedge rst_sync_b) begin
        if (!rst_sync_b)
            dq_oe <= 1'b0;
        else if (output_enable_b || sleep_request)
            dq_oe <= 1'b0;
        else
            dq_oe <= rd_valid_r && !first_read_r;
    end

    property p_select_load;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (load && !selected) |=> cyc_r == sram_pkg::ST_DESEL;
    endproperty
    a_select_load: assert property (p_select_load)
        else $error("deselect missed");
    property p_proc_prio;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (!in_r.proc_strobe_b && !in_r.cs_primary_b && selected)
        |=> cyc_r == sram_pkg::ST_READ;
    endproperty
    a_proc_prio: assert property (p_proc_prio)
        else $error("processor strobe lost");
    property p_global;
        @(posedge sys_clk) !in_r.write_all_b |-> wr_lanes == `ALL_LANES;
    endproperty
    a_global: assert property (p_global)
        else $error("global write lanes");
    property p_gate;
        @(posedge sys_clk) (in_r.write_all_b && in_r.lane_gate_b)
        |-> wr_lanes == `NO_LANES;
    endproperty
    a_gate: assert property (p_gate)
        else $error("lanes without gate");
    property p_oe_off;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        output_enable_b |=> !dq_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("driving with oe high");
    property p_wrap;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        !load |=> word_addr[ADDR_W-1:`BURST_W]
        == $past(word_addr[ADDR_W-1:`BURST_W]);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("burst left block");
    property p_load_addr;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        load |=> addr_r == $past(in_r.addr);
    endproperty
    a_load_addr: assert property (p_load_addr)
        else $error("address not loaded");
    property p_hold;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        (!load && in_r.advance_b) |=> $stable(low_bits);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved without advance");
    property p_first_mask;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        first_read_r |=> !dq_oe;
    endproperty
    a_first_mask: assert property (p_first_mask)
        else $error("first read not masked");
    property p_proc_no_write;
        @(posedge sys_clk) disable iff (!rst_sync_b)
        proc_go |=> wlanes_r == `NO_LANES;
    endproperty
    a_proc_no_write: assert property (p_proc_no_write)
        else $error("processor strobe wrote");
    c_write: cover property (@(posedge sys_clk) cyc_r == sram_pkg::ST_WRITE);
    c_burst: cover property (@(posedge sys_clk)
        load ##1 (!in_r.advance_b)[*3]);
    c_oe: cover property (@(posedge sys_clk) dq_oe);
endmodule

/* File: tb/host_model.sv */
// far side of the shared data pins: resolves the wire and flags clashes
module host_model (
    input wire logic sys_clk,
    input wire logic drive,
    input wire logic [31:0] wdata,
    input wire logic [31:0] dq_out,
    input wire logic dq_oe,
    output logic [31:0] dq_in,
    output logic clash
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] last_r = 32'h0;
    always_ff @(posedge sys_clk) begin
        last_r <= dq_in;
    end
    // one driver at a time
    // released bus toggles so stale data never reads back
    assign dq_in = dq_oe ? dq_out : (drive ? wdata : ~last_r);
    assign clash = dq_oe && drive;
endmodule

/* File: tb/pipelined_burst_sync_sram_tb.sv */
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    n_fail++; $display("ERROR %s exp %h got %h", n, e, s); end end
module pipelined_burst_sync_sram_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam sram_pkg::bus_in_t IDLE = {18'h0, 6'b111010, 4'hF, 2'b11};
    localparam logic [17:0] B = 18'h2A5F0;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    // device keeps the pins released while the host writes
    logic oe_b = 1'b1;
    logic sleep = 1'b0;
    logic lin = 1'b0;
    logic hd = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] dq_in;
    logic [31:0] dq_out;
    logic dq_oe;
    logic clash;
    logic [31:0] sh [4];
    int n_fail = 0;
    int comparisons = 0;
    sram_pkg::bus_in_t bi = IDLE;

    initial forever #25 sys_clk = ~sys_clk;

    pipelined_burst_sync_sram dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .addr(bi.addr), .processor_address_strobe_b(bi.proc_strobe_b),
        .controller_address_strobe_b(bi.ctrl_strobe_b),
        .burst_advance_b(bi.advance_b),
        .chip_select_primary_b(bi.cs_primary_b),
        .chip_select_active_high(bi.cs_high),
        .chip_select_third_b(bi.cs_third_b),
        .byte_lane_selects_b(bi.lanes_b),
        .byte_write_gate_b(bi.lane_gate_b),
        .write_all_lanes_b(bi.write_all_b), .output_enable_b(oe_b),
        .sleep_request(sleep), .linear_burst(lin), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe));
    host_model host_u (.sys_clk(sys_clk), .drive(hd), .wdata(wd),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .clash(clash));

    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ctl is {proc strobe, select high, write all, lane gate}
    task automatic op(input logic [17:0] a, input logic [3:0] ctl,
                      input logic [3:0] ln, input logic [31:0] d);
        sram_pkg::bus_in_t t;
        t = IDLE;
        t.addr = a;
        t.ctrl_strobe_b = 1'b0;
        t.proc_strobe_b = ctl[3];
        t.cs_high = ctl[2];
        t.write_all_b = ctl[1];
        t.lane_gate_b = ctl[0];
        t.lanes_b = ln;
        @(posedge sys_clk);
        bi <= t;
        wd <= d;
        hd <= 1'b1;
        @(posedge sys_clk);
        bi <= IDLE;
        hd <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic rd(input logic [17:0] a, input int n, input logic m0);
        sram_pkg::bus_in_t t;
        logic [1:0] k;
        t = IDLE;
        t.addr = a;
        t.ctrl_strobe_b = 1'b0;
        @(posedge sys_clk);
        bi <= t;
        t = IDLE;
        t.advance_b = 1'b0;
        @(posedge sys_clk);
        bi <= t;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            @(negedge sys_clk);
            k = lin ? a[1:0] + 2'(i) : a[1:0] ^ 2'(i);
            `CHK("dq_out", sh[k], dq_out)
            if (m0 && i == 0) `CHK("dq_oe first", 1'b0, dq_oe)
            if (i == 2) `CHK("dq_oe", 1'b1, dq_oe)
        end
    endtask

    // host never drives while the device does
    always @(negedge sys_clk) begin
        if (clash === 1'b1) begin
            n_fail++;
            $display("ERROR bus clash exp 0 got 1");
        end
    end

    // the whole test runs about 100 cycles; 2000 is ample margin
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge sys_clk);
        // write all lanes overrides gate and lanes
        for (int i = 0; i < 4; i++) begin
            sh[i] = 32'h5A00_0000 ^ (32'(i) * 32'h0123_4567);
            op(B + 18'(i), 4'b1101, 4'h0, sh[i]);
        end
        // gate low writes lanes 0 and 2 only
        op(B + 18'h1, 4'b1110, 4'hA, 32'h1122_3344);
        sh[1] = {sh[1][31:24], 8'h22, sh[1][15:8], 8'h44};
        op(B + 18'h2, 4'b1111, 4'h0, 32'hFFFF_FFFF);
        // processor strobe wins, so no write
        op(B, 4'b0101, 4'hF, 32'hFFFF_FFFF);
        op(B + 18'h3, 4'b1001, 4'hF, 32'hFFFF_FFFF);
        @(posedge sys_clk) oe_b <= 1'b0;
        rd(B + 18'h3, 4, 1'b1);
        @(posedge sys_clk);
        bi <= IDLE;
        lin <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(B + 18'h1, 4, 1'b0);
        // oe and sleep act between edges
        @(posedge sys_clk) oe_b <= 1'b1;
        #5 `CHK("dq_oe oe", 1'b0, dq_oe)
        @(posedge sys_clk) begin
            oe_b <= 1'b0;
            sleep <= 1'b1;
        end
        #5 `CHK("dq_oe sleep", 1'b0, dq_oe)
        @(posedge sys_clk) sleep <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(B + 18'h2, 4, 1'b0);
        end_of_test();
    end
endmodule
